// ### tci_regs.svh
// tci_regs.svh: offsets, field positions and bit numbers of the time
// capture and interrupt register block; assumes byte addresses.
`ifndef TCI_REGS_SVH
`define TCI_REGS_SVH
`define TCI_OFS_TIME_REQ 7'h00
`define TCI_OFS_EVENT_REQ 7'h04
`define TCI_OFS_REARM1 7'h08
`define TCI_OFS_REARM2 7'h0c
`define TCI_OFS_CONTROL 7'h10
`define TCI_OFS_HANDSHAKE 7'h14
`define TCI_OFS_INT_ENABLE 7'h18
`define TCI_OFS_INT_PENDING 7'h1c
`define TCI_OFS_STRB_MINOR 7'h20
`define TCI_OFS_STRB_MAJOR 7'h24
`define TCI_OFS_CAP2_MINOR 7'h28
`define TCI_OFS_CAP2_MAJOR 7'h2c
`define TCI_OFS_SW_MINOR 7'h30
`define TCI_OFS_SW_MAJOR 7'h34
`define TCI_OFS_CAP1_MINOR 7'h38
`define TCI_OFS_CAP1_MAJOR 7'h3c
`define TCI_OFS_REARM3 7'h44
`define TCI_OFS_CAP3_MINOR 7'h48
`define TCI_OFS_CAP3_MAJOR 7'h4c
`define TCI_CTL_LOCK1 0
`define TCI_CTL_EVSRC 1
`define TCI_CTL_SENSE1 2
`define TCI_CTL_EN1 3
`define TCI_CTL_STRB_EN 4
`define TCI_CTL_STRB_MINOR_ONLY 5
`define TCI_CTL_LOCK2 8
`define TCI_CTL_SENSE2 9
`define TCI_CTL_EN2 10
`define TCI_CTL_LOCK3 12
`define TCI_CTL_SENSE3 13
`define TCI_CTL_EN3 14
`define TCI_CTL_MASK 32'h0000_77ff
`define TCI_IRQ_EVENT 0
`define TCI_IRQ_PERIODIC 1
`define TCI_IRQ_STROBE 2
`define TCI_IRQ_PPS 3
`define TCI_IRQ_GPS 4
`define TCI_IRQ_EV2 5
`define TCI_IRQ_EV3 6
`define TCI_IRQ_RNG 6:0
`define TCI_USEC_RNG 19:0
`define TCI_HNS_RNG 23:20
`define TCI_STAT_RNG 27:24
`define TCI_DAY8_BIT 28
`define TCI_DAY_RNG 31:24
`define TCI_HOUR_RNG 20:16
`define TCI_MIN_RNG 12:8
`define TCI_SEC_RNG 5:0
`define TCI_STRB_SEC_RNG 21:0
`endif

// ### tci_pkg.sv
// tci_pkg.sv: types shared by the time capture and interrupt block.
// assumes tci_regs.svh for all numeric layout.
package tci_pkg;
	typedef logic [31:0] tci_word_t;
	// capture slots, also the index into the holding register storage
	typedef enum logic [1:0] {
		TCI_CAP_SW,
		TCI_CAP_EV1,
		TCI_CAP_EV2,
		TCI_CAP_EV3
	} tci_cap_e;
endpackage

// ### tci_time_capture.sv
// tci_time_capture.sv: interrupt enable/pending pair, coincidence strobe
// compare and time capture holding registers of the time processor.
// assumes a time base on i_core_clk and a register access port from the
// host bus target, one access per request, read data one cycle later.
`timescale 1ns/1ps
`include "tci_regs.svh"

module tci_time_capture (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [6:0] i_reg_addr,
	input wire logic i_reg_rd,
	input wire logic i_reg_wr,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	output logic o_reg_rvalid,
	input wire logic i_time_fmt_binary,
	input wire logic [31:0] i_tb_seconds,
	input wire logic [8:0] i_tb_day,
	input wire logic [4:0] i_tb_hour,
	input wire logic [5:0] i_tb_min,
	input wire logic [5:0] i_tb_sec,
	input wire logic [19:0] i_tb_usec,
	input wire logic [3:0] i_tb_hns,
	input wire logic [3:0] i_tb_status,
	input wire logic i_first_input_capture_major_pin,
	input wire logic i_event2_pin,
	input wire logic i_event3_pin,
	input wire logic i_periodic_pulse,
	input wire logic i_pps_pulse,
	input wire logic i_gps_packet_pulse,
	input wire logic i_int_started,
	output logic o_irq,
	output logic o_strobe
);

	function automatic logic edge_hit(input logic cur, input logic prev,
		input logic falling);
		edge_hit = falling ? (prev & ~cur) : (cur & ~prev);
	endfunction

	function automatic logic acc_hit(input logic [6:0] ofs);
		acc_hit = (i_reg_rd | i_reg_wr) && (i_reg_addr == ofs);
	endfunction

	logic [31:0] ctrl_reg;
	logic [6:0] irq_en_reg;
	logic [6:0] pend_reg;
	logic [19:0] strb_min_reg;
	logic [31:0] strb_maj_reg;
	logic [2:0] ev_meta_reg;
	logic [2:0] ev_sync_reg;
	logic [2:0] ev_prev_reg;
	logic [3:1] lock_reg;
	logic match_prev_reg;
	tci_pkg::tci_word_t cap_min_reg [4];
	tci_pkg::tci_word_t cap_maj_reg [4];

	logic e1_pin_edge;
	logic e2_edge;
	logic e3_edge;
	logic ev1_src;
	logic [3:0] cap_load;
	logic [3:1] cap_by_input;
	logic [3:1] rearm_hit;
	logic [6:0] irq_set;
	logic [6:0] pend_clr;
	logic major_eq;
	logic match_now;
	logic strobe_hit;
	tci_pkg::tci_word_t minor_now;
	tci_pkg::tci_word_t major_now;
	tci_pkg::tci_word_t rd_mux;

	// event pins are asynchronous; only the second and third stages feed logic
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ev_meta_reg <= 3'h0;
			ev_sync_reg <= 3'h0;
			ev_prev_reg <= 3'h0;
		end else begin
			ev_meta_reg <= {i_event3_pin, i_event2_pin, i_first_input_capture_major_pin};
			ev_sync_reg <= ev_meta_reg;
			ev_prev_reg <= ev_sync_reg;
		end
	end

	assign e1_pin_edge = edge_hit(ev_sync_reg[0], ev_prev_reg[0],
		ctrl_reg[`TCI_CTL_SENSE1]);
	assign e2_edge = edge_hit(ev_sync_reg[1], ev_prev_reg[1],
		ctrl_reg[`TCI_CTL_SENSE2]);
	assign e3_edge = edge_hit(ev_sync_reg[2], ev_prev_reg[2],
		ctrl_reg[`TCI_CTL_SENSE3]);
	// the periodic source arrives as a pulse, so it needs no edge select
	assign ev1_src = ctrl_reg[`TCI_CTL_EVSRC] ? i_periodic_pulse : e1_pin_edge;

	// current time in register layout; minor is binary in both formats, and outside binary format also carries day bit 8 at TCI_DAY8_BIT
	always_comb begin
		minor_now = 32'h0;
		minor_now[`TCI_USEC_RNG] = i_tb_usec;
		minor_now[`TCI_HNS_RNG] = i_tb_hns;
		minor_now[`TCI_STAT_RNG] = i_tb_status;
		major_now = 32'h0;
		if (i_time_fmt_binary) begin
			major_now = i_tb_seconds;
		end else begin
			minor_now[`TCI_DAY8_BIT] = i_tb_day[8];
			major_now[`TCI_DAY_RNG] = i_tb_day[7:0];
			major_now[`TCI_HOUR_RNG] = i_tb_hour;
			// minute field is five bits wide as laid out
			major_now[`TCI_MIN_RNG] = i_tb_min[4:0];
			major_now[`TCI_SEC_RNG] = i_tb_sec;
		end
	end

	assign rearm_hit = {acc_hit(`TCI_OFS_REARM3), acc_hit(`TCI_OFS_REARM2),
		acc_hit(`TCI_OFS_REARM1)};
	assign cap_by_input[1] = ctrl_reg[`TCI_CTL_EN1] & ev1_src & ~lock_reg[1];
	assign cap_by_input[2] = ctrl_reg[`TCI_CTL_EN2] & e2_edge & ~lock_reg[2];
	assign cap_by_input[3] = ctrl_reg[`TCI_CTL_EN3] & e3_edge & ~lock_reg[3];
	assign cap_load[tci_pkg::TCI_CAP_SW] = acc_hit(`TCI_OFS_TIME_REQ);
	assign cap_load[tci_pkg::TCI_CAP_EV1] = acc_hit(`TCI_OFS_EVENT_REQ)
		| cap_by_input[1];
	assign cap_load[tci_pkg::TCI_CAP_EV2] = cap_by_input[2];
	assign cap_load[tci_pkg::TCI_CAP_EV3] = cap_by_input[3];

	// holding registers carry no reset: software must capture first
	always_ff @(posedge i_core_clk) begin
		for (int i = 0; i < 4; i++) begin
			if (cap_load[i]) begin
				cap_min_reg[i] <= minor_now;
				cap_maj_reg[i] <= major_now;
			end
		end
	end

	// a capture in the same cycle as a release keeps the lock
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			lock_reg <= 3'h0;
		end else begin
			lock_reg <= (lock_reg & ~rearm_hit) | (cap_by_input & {
				ctrl_reg[`TCI_CTL_LOCK3], ctrl_reg[`TCI_CTL_LOCK2],
				ctrl_reg[`TCI_CTL_LOCK1]});
		end
	end

	// strobe compare at microsecond resolution
	always_comb begin
		if (i_time_fmt_binary) begin
			major_eq = i_tb_seconds[`TCI_STRB_SEC_RNG]
				== strb_maj_reg[`TCI_STRB_SEC_RNG];
		end else begin
			major_eq = (i_tb_hour == strb_maj_reg[`TCI_HOUR_RNG])
				&& (i_tb_min[4:0] == strb_maj_reg[`TCI_MIN_RNG])
				&& (i_tb_sec == strb_maj_reg[`TCI_SEC_RNG]);
		end
	end
	assign match_now = (i_tb_usec == strb_min_reg)
		&& (ctrl_reg[`TCI_CTL_STRB_MINOR_ONLY] || major_eq);
	// the time base holds a microsecond for many cycles; fire once on entry
	assign strobe_hit = match_now & ~match_prev_reg;

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			match_prev_reg <= 1'b0;
			o_strobe <= 1'b0;
		end else begin
			match_prev_reg <= match_now;
			// gating after the edge detect keeps the status bit live while disabled
			o_strobe <= strobe_hit & ctrl_reg[`TCI_CTL_STRB_EN];
		end
	end

	always_comb begin
		irq_set = 7'h0;
		// only the selected event source counts; the request location never sets it
		irq_set[`TCI_IRQ_EVENT] = ctrl_reg[`TCI_CTL_EN1] & ev1_src;
		irq_set[`TCI_IRQ_PERIODIC] = i_periodic_pulse;
		irq_set[`TCI_IRQ_STROBE] = strobe_hit;
		irq_set[`TCI_IRQ_PPS] = i_pps_pulse;
		irq_set[`TCI_IRQ_GPS] = i_gps_packet_pulse;
		irq_set[`TCI_IRQ_EV2] = ctrl_reg[`TCI_CTL_EN2] & e2_edge;
		irq_set[`TCI_IRQ_EV3] = ctrl_reg[`TCI_CTL_EN3] & e3_edge;
	end
	assign pend_clr = (i_reg_wr && i_reg_addr == `TCI_OFS_INT_PENDING)
		? i_reg_wdata[`TCI_IRQ_RNG] : 7'h0;

	// set beats clear so an event meeting the clear write is kept
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pend_reg <= 7'h0;
		end else begin
			pend_reg <= (pend_reg & ~pend_clr) | irq_set;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= (|(pend_reg & irq_en_reg)) & i_int_started;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_reg <= 32'h0;
			irq_en_reg <= 7'h0;
			strb_min_reg <= 20'h0;
			strb_maj_reg <= 32'h0;
		end else if (i_reg_wr) begin
			unique case (i_reg_addr)
				`TCI_OFS_CONTROL: begin
					ctrl_reg <= i_reg_wdata & `TCI_CTL_MASK;
				end
				`TCI_OFS_INT_ENABLE: begin
					irq_en_reg <= i_reg_wdata[`TCI_IRQ_RNG];
				end
				`TCI_OFS_STRB_MINOR: begin
					strb_min_reg <= i_reg_wdata[`TCI_USEC_RNG];
				end
				`TCI_OFS_STRB_MAJOR: begin
					strb_maj_reg <= i_reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h0;
		unique case (i_reg_addr)
			`TCI_OFS_CONTROL: rd_mux = ctrl_reg;
			`TCI_OFS_INT_ENABLE: rd_mux[`TCI_IRQ_RNG] = irq_en_reg;
			`TCI_OFS_INT_PENDING: rd_mux[`TCI_IRQ_RNG] = pend_reg;
			`TCI_OFS_STRB_MINOR: rd_mux[`TCI_USEC_RNG] = strb_min_reg;
			`TCI_OFS_STRB_MAJOR: rd_mux = strb_maj_reg;
			`TCI_OFS_CAP2_MINOR: rd_mux = cap_min_reg[tci_pkg::TCI_CAP_EV2];
			`TCI_OFS_CAP2_MAJOR: rd_mux = cap_maj_reg[tci_pkg::TCI_CAP_EV2];
			`TCI_OFS_SW_MINOR: rd_mux = cap_min_reg[tci_pkg::TCI_CAP_SW];
			`TCI_OFS_SW_MAJOR: rd_mux = cap_maj_reg[tci_pkg::TCI_CAP_SW];
			`TCI_OFS_CAP1_MINOR: rd_mux = cap_min_reg[tci_pkg::TCI_CAP_EV1];
			`TCI_OFS_CAP1_MAJOR: rd_mux = cap_maj_reg[tci_pkg::TCI_CAP_EV1];
			`TCI_OFS_CAP3_MINOR: rd_mux = cap_min_reg[tci_pkg::TCI_CAP_EV3];
			`TCI_OFS_CAP3_MAJOR: rd_mux = cap_maj_reg[tci_pkg::TCI_CAP_EV3];
			default: rd_mux = 32'h0;
		endcase
	end

	// read data reflects the registers before any capture by this access
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 32'h0;
			o_reg_rvalid <= 1'b0;
		end else begin
			o_reg_rvalid <= i_reg_rd;
			if (i_reg_rd) begin
				o_reg_rdata <= rd_mux;
			end
		end
	end

	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (!i_rst_n);

	chk_irq_gate_on: assert property (
		((|(pend_reg & irq_en_reg)) && i_int_started) |=> o_irq)
		else $error("interrupt not raised for enabled pending source");
	chk_irq_gate_off: assert property (
		(pend_reg & irq_en_reg) == 7'h0 |=> !o_irq)
		else $error("interrupt raised with no enabled pending source");
	chk_pend_sticky: assert property (
		!(i_reg_wr && i_reg_addr == `TCI_OFS_INT_PENDING)
		|=> (pend_reg & $past(pend_reg)) == $past(pend_reg))
		else $error("pending bit lost without a clear write");
	chk_pend_w1c_clear: assert property (
		(i_reg_wr && i_reg_addr == `TCI_OFS_INT_PENDING)
		|=> (pend_reg & $past(pend_clr) & ~$past(irq_set)) == 7'h0)
		else $error("pending bit not cleared by a one write");
	chk_pend_set_seen: assert property (
		irq_set != 7'h0 |=> (pend_reg & $past(irq_set)) == $past(irq_set))
		else $error("source event did not set pending bit");
	chk_strobe_held_low: assert property (
		!ctrl_reg[`TCI_CTL_STRB_EN] |=> !o_strobe)
		else $error("strobe driven while disabled");
	chk_strobe_on_match: assert property (
		o_strobe |-> $past(match_now) && !$past(match_prev_reg)
		&& pend_reg[`TCI_IRQ_STROBE])
		else $error("strobe without a fresh match");
	chk_sw_capture_load: assert property (
		acc_hit(`TCI_OFS_TIME_REQ)
		|=> cap_maj_reg[tci_pkg::TCI_CAP_SW] == $past(major_now)
		&& cap_min_reg[tci_pkg::TCI_CAP_SW][`TCI_USEC_RNG] == $past(i_tb_usec))
		else $error("software capture did not load current time");
	chk_lock_holds_ev3: assert property (
		lock_reg[3] && !rearm_hit[3]
		|=> $stable(cap_maj_reg[tci_pkg::TCI_CAP_EV3]) && lock_reg[3])
		else $error("third capture changed while locked");
	chk_rearm_third: assert property (
		rearm_hit[3] && !cap_by_input[3] |=> !lock_reg[3])
		else $error("third lockout not released by rearm access");
	chk_req_no_event_irq: assert property (
		acc_hit(`TCI_OFS_EVENT_REQ) && !irq_set[`TCI_IRQ_EVENT]
		&& !pend_reg[`TCI_IRQ_EVENT] |=> !pend_reg[`TCI_IRQ_EVENT])
		else $error("event request set event interrupt bit");

	cov_strobe_fire: cover property (o_strobe);
	cov_third_locked: cover property (lock_reg[3] ##1 rearm_hit[3]);
	cov_irq_raised: cover property (!o_irq ##1 o_irq);
	cov_set_meets_clear: cover property ((irq_set & pend_clr) != 7'h0);
	cov_minor_only_strobe: cover property (o_strobe && ctrl_reg[`TCI_CTL_STRB_MINOR_ONLY]);

endmodule

// ### tci_host_model.sv
// tci_host_model.sv: host software side of the register port, one access per request.
// assumes requests are launched on the falling edge of the core clock.
`timescale 1ns/1ps

module tci_host_model (
	input wire logic i_core_clk,
	input wire logic [31:0] i_reg_rdata,
	input wire logic i_reg_rvalid,
	output logic [6:0] o_reg_addr,
	output logic o_reg_rd,
	output logic o_reg_wr,
	output logic [31:0] o_reg_wdata
);
	initial begin
		o_reg_addr = 7'h7f;
		o_reg_rd = 1'b0;
		o_reg_wr = 1'b0;
		o_reg_wdata = 32'h0;
	end

	// address and data are turned over after release so stale values never look valid
	task automatic wr_reg(input logic [6:0] a, input logic [31:0] d);
		@(negedge i_core_clk);
		o_reg_addr = a;
		o_reg_wdata = d;
		o_reg_wr = 1'b1;
		@(negedge i_core_clk);
		o_reg_wr = 1'b0;
		o_reg_addr = ~a;
		o_reg_wdata = ~d;
	endtask

	// one pulse per access; answer is taken one cycle after the request
	task automatic rd_reg(input logic [6:0] a, output logic [31:0] d, output logic v);
		@(negedge i_core_clk);
		o_reg_addr = a;
		o_reg_rd = 1'b1;
		@(negedge i_core_clk);
		o_reg_rd = 1'b0;
		o_reg_addr = ~a;
		d = i_reg_rdata;
		v = i_reg_rvalid;
	endtask
endmodule

// ### time_capture_interrupt_regs_tb_top.sv
// time_capture_interrupt_regs_tb_top.sv: self-checking bench of the capture and interrupt block.
// assumes tci_regs.svh offsets and the host model for all register traffic.
`timescale 1ns/1ps
`include "tci_regs.svh"
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin miscompares++; \
	$display("[ERR] %0t got %h expected %h", $time, (got), (exp)); end end

module time_capture_interrupt_regs_tb_top;
	logic clk, rst_n, fmt_bin, ev1, ev2, ev3, per, pps, gps, started, irq, strobe;
	logic [6:0] addr;
	logic rd, wr, rvalid;
	logic [31:0] wdata, rdata, secs;
	logic [8:0] day;
	logic [4:0] hour;
	logic [5:0] mins, sec;
	logic [19:0] usec;
	logic [3:0] hns, stat;
	int miscompares = 0;
	int check_count = 0;

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	tci_host_model host (.i_core_clk(clk), .i_reg_rdata(rdata), .i_reg_rvalid(rvalid),
		.o_reg_addr(addr), .o_reg_rd(rd), .o_reg_wr(wr), .o_reg_wdata(wdata));

	tci_time_capture uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_reg_addr(addr), .i_reg_rd(rd),
		.i_reg_wr(wr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
		.i_time_fmt_binary(fmt_bin), .i_tb_seconds(secs), .i_tb_day(day), .i_tb_hour(hour),
		.i_tb_min(mins), .i_tb_sec(sec), .i_tb_usec(usec), .i_tb_hns(hns), .i_tb_status(stat),
		.i_first_input_capture_major_pin(ev1), .i_event2_pin(ev2), .i_event3_pin(ev3), .i_periodic_pulse(per),
		.i_pps_pulse(pps), .i_gps_packet_pulse(gps), .i_int_started(started), .o_irq(irq),
		.o_strobe(strobe));

	task automatic chk_rd(input logic [6:0] a, input logic [31:0] e, input logic [31:0] m);
		logic [31:0] d;
		logic v;
		host.rd_reg(a, d, v);
		`CHK(v, 1'b1)
		`CHK(d & m, e & m)
	endtask

	task automatic pulse_pin(ref logic p);
		@(negedge clk) p = 1'b1;
		repeat (5) @(negedge clk);
		p = 1'b0;
		repeat (5) @(negedge clk);
	endtask

	task automatic pulse1(ref logic p);
		@(negedge clk) p = 1'b1;
		@(negedge clk) p = 1'b0;
		repeat (3) @(negedge clk);
	endtask

	// minor word for the current running time, binary layout
	function automatic logic [31:0] minor_now();
		return {4'h0, stat, hns, usec};
	endfunction

	task automatic t_irq();
		host.wr_reg(`TCI_OFS_INT_PENDING, 32'h7f);
		host.wr_reg(`TCI_OFS_INT_ENABLE, 32'h08);
		pulse1(pps);
		`CHK(irq, 1'b1)
		host.wr_reg(`TCI_OFS_INT_PENDING, 32'h00);
		chk_rd(`TCI_OFS_INT_PENDING, 32'h08, 32'h7f);
		host.wr_reg(`TCI_OFS_INT_ENABLE, 32'h77);
		chk_rd(`TCI_OFS_INT_ENABLE, 32'h77, 32'h7f);
		`CHK(irq, 1'b0)
		pulse1(gps);
		chk_rd(`TCI_OFS_INT_PENDING, 32'h18, 32'h7f);
		`CHK(irq, 1'b1)
		@(negedge clk) started = 1'b0;
		repeat (2) @(negedge clk);
		`CHK(irq, 1'b0)
		started = 1'b1;
		host.wr_reg(`TCI_OFS_INT_PENDING, 32'h7f);
		chk_rd(`TCI_OFS_INT_PENDING, 32'h00, 32'h7f);
		`CHK(irq, 1'b0)
	endtask

	task automatic t_swcap();
		fmt_bin = 1'b1;
		chk_rd(`TCI_OFS_TIME_REQ, 32'h0, 32'h0);
		chk_rd(`TCI_OFS_SW_MAJOR, secs, 32'hffffffff);
		chk_rd(`TCI_OFS_SW_MINOR, minor_now(), 32'h0fffffff);
		host.wr_reg(`TCI_OFS_SW_MAJOR, 32'h0);
		chk_rd(`TCI_OFS_SW_MAJOR, secs, 32'hffffffff);
		chk_rd(7'h40, 32'h0, 32'hffffffff);
		@(negedge clk) fmt_bin = 1'b0;
		host.wr_reg(`TCI_OFS_TIME_REQ, 32'h0);
		chk_rd(`TCI_OFS_SW_MAJOR, 32'h6d171e3b, 32'hff1f1f3f);
		chk_rd(`TCI_OFS_SW_MINOR, minor_now() | 32'h10000000, 32'h1fffffff);
		@(negedge clk) fmt_bin = 1'b1;
	endtask

	task automatic t_ev1();
		host.wr_reg(`TCI_OFS_INT_PENDING, 32'h7f);
		chk_rd(`TCI_OFS_EVENT_REQ, 32'h0, 32'h0);
		chk_rd(`TCI_OFS_CAP1_MAJOR, secs, 32'hffffffff);
		chk_rd(`TCI_OFS_INT_PENDING, 32'h00, 32'h7f);
		host.wr_reg(`TCI_OFS_CONTROL, 32'h0a);
		@(negedge clk) usec = 20'h00321;
		pulse1(per);
		chk_rd(`TCI_OFS_CAP1_MINOR, minor_now(), 32'h0fffffff);
		chk_rd(`TCI_OFS_INT_PENDING, 32'h03, 32'h7f);
	endtask

	task automatic t_ev23();
		host.wr_reg(`TCI_OFS_INT_PENDING, 32'h7f);
		host.wr_reg(`TCI_OFS_CONTROL, 32'h5400);
		pulse_pin(ev2);
		chk_rd(`TCI_OFS_CAP2_MAJOR, secs, 32'hffffffff);
		pulse_pin(ev3);
		chk_rd(`TCI_OFS_CAP3_MINOR, minor_now(), 32'h0fffffff);
		chk_rd(`TCI_OFS_INT_PENDING, 32'h60, 32'h7f);
		@(negedge clk) usec = 20'h54321;
		pulse_pin(ev3);
		chk_rd(`TCI_OFS_CAP3_MINOR, {12'h037, 20'h00321}, 32'h0fffffff);
		chk_rd(`TCI_OFS_REARM3, 32'h0, 32'h0);
		pulse_pin(ev3);
		chk_rd(`TCI_OFS_CAP3_MINOR, minor_now(), 32'h0fffffff);
		chk_rd(`TCI_OFS_CAP3_MAJOR, secs, 32'hffffffff);
	endtask

	// falling sense with lockout: the value at the fall is kept until rearm
	task automatic t_ev1_pin();
		host.wr_reg(`TCI_OFS_INT_PENDING, 32'h7f);
		host.wr_reg(`TCI_OFS_CONTROL, 32'h0d);
		@(negedge clk) usec = 20'h00111;
		ev1 = 1'b1;
		repeat (5) @(negedge clk);
		usec = 20'h00222;
		ev1 = 1'b0;
		repeat (5) @(negedge clk);
		chk_rd(`TCI_OFS_CAP1_MINOR, {12'h037, 20'h00222}, 32'h0fffffff);
		usec = 20'h00333;
		pulse_pin(ev1);
		chk_rd(`TCI_OFS_CAP1_MINOR, {12'h037, 20'h00222}, 32'h0fffffff);
		chk_rd(`TCI_OFS_REARM1, 32'h0, 32'h0);
		usec = 20'h00444;
		pulse_pin(ev1);
		chk_rd(`TCI_OFS_CAP1_MINOR, {12'h037, 20'h00444}, 32'h0fffffff);
		chk_rd(`TCI_OFS_INT_PENDING, 32'h01, 32'h7f);
	endtask

	task automatic strobe_hits(input logic [19:0] hit, output int n);
		n = 0;
		@(negedge clk) usec = hit;
		repeat (4) @(negedge clk) n += (strobe === 1'b1);
		usec = hit + 20'h1;
		repeat (2) @(negedge clk);
	endtask

	task automatic t_strobe();
		int n;
		// output stays disabled while the compare time is rewritten
		host.wr_reg(`TCI_OFS_CONTROL, 32'h0);
		host.wr_reg(`TCI_OFS_STRB_MAJOR, 32'h00011234);
		host.wr_reg(`TCI_OFS_STRB_MINOR, 32'h00000100);
		chk_rd(`TCI_OFS_STRB_MAJOR, 32'h00011234, 32'h003fffff);
		host.wr_reg(`TCI_OFS_INT_PENDING, 32'h7f);
		host.wr_reg(`TCI_OFS_CONTROL, 32'h10);
		@(negedge clk) secs = 32'h1fc11234;
		strobe_hits(20'h00100, n);
		`CHK(n, 1)
		chk_rd(`TCI_OFS_INT_PENDING, 32'h04, 32'h7f);
		host.wr_reg(`TCI_OFS_INT_PENDING, 32'h7f);
		host.wr_reg(`TCI_OFS_CONTROL, 32'h00);
		strobe_hits(20'h00100, n);
		`CHK(n, 0)
		chk_rd(`TCI_OFS_INT_PENDING, 32'h04, 32'h7f);
		host.wr_reg(`TCI_OFS_CONTROL, 32'h30);
		@(negedge clk) secs = 32'h00000007;
		strobe_hits(20'h00100, n);
		`CHK(n, 1)
	endtask

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial begin
		#200us;
		miscompares++;
		final_report();
	end

	initial begin
		rst_n = 1'b0;
		{ev1, ev2, ev3, per, pps, gps} = 6'h0;
		started = 1'b1;
		fmt_bin = 1'b1;
		secs = 32'h5a5a1234;
		{day, hour, mins, sec} = {9'h16d, 5'h17, 6'h1e, 6'h3b};
		{stat, hns, usec} = {4'h3, 4'h7, 20'h7a11f};
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		t_irq();
		t_swcap();
		t_ev1();
		t_ev23();
		t_ev1_pin();
		t_strobe();
		final_report();
	end
endmodule
